//--- src/common_sig_pkg.sv
/*
  Shared constants and types for the common start/trip aggregator:
  register offsets, control field positions, reset values, event codes and carriers.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package common_sig_pkg;

  // Sizes of the stage and user matrix inputs, event count, stamp and counter widths
  localparam int unsigned NUM_STAGES = 32;
  localparam int unsigned NUM_EXTRA = 16;
  localparam int unsigned NUM_EVENTS = 4;
  localparam int unsigned STAMP_W = 32;
  localparam int unsigned CNT_W = 32;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_START_CNT = 8'h08;
  localparam logic [7:0] ADDR_TRIP_CNT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_EXTRA_START_SEL = 8'h18;
  localparam logic [7:0] ADDR_EXTRA_TRIP_SEL = 8'h1C;
  localparam logic [7:0] ADDR_LAST_EVENT = 8'h20;
  localparam logic [7:0] ADDR_LAST_STAMP = 8'h24;

  // Control register fields
  localparam int unsigned CTRL_FORCE_LSB = 0;
  localparam int unsigned CTRL_LOG_LSB = 4;
  localparam int unsigned CTRL_CNT_CLR_BIT = 8;

  // Status register fields
  localparam int unsigned STAT_COND_LSB = 0;
  localparam int unsigned STAT_START_BIT = 2;
  localparam int unsigned STAT_TRIP_BIT = 3;
  localparam int unsigned STAT_PERMIT_BIT = 4;

  // Event bit positions, also the event codes
  localparam int unsigned EVT_START_ON = 0;
  localparam int unsigned EVT_START_OFF = 1;
  localparam int unsigned EVT_TRIP_ON = 2;
  localparam int unsigned EVT_TRIP_OFF = 3;

  // Forced state selector values
  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'b00,
    FORCE_START = 2'b01,
    FORCE_TRIP = 2'b10
  } forced_state_t;

  // Readable condition values
  typedef enum logic [1:0] {
    COND_NORMAL = 2'b00,
    COND_START = 2'b01,
    COND_TRIP = 2'b10
  } condition_t;

  // Event masking choices
  typedef enum logic [1:0] {
    LOG_BOTH = 2'b00,
    LOG_ON_ONLY = 2'b01,
    LOG_OFF_ONLY = 2'b10
  } log_mode_t;

  // Reset values
  localparam logic [NUM_EVENTS-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [NUM_EXTRA-1:0] EXTRA_SEL_RESET = 16'h0000;

  // Control settings held by the block
  typedef struct packed {
    log_mode_t log_mode;
    forced_state_t forced_state_select;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{log_mode: LOG_BOTH, forced_state_select: FORCE_NORMAL};

  // Record handed to the main event buffer
  typedef struct packed {
    logic valid;
    logic [1:0] code;
    logic [STAMP_W-1:0] stamp;
  } event_rec_t;

  localparam event_rec_t EVENT_REC_RESET = '{valid: 1'b0, code: 2'b00, stamp: 32'h0000_0000};

endpackage : common_sig_pkg

//--- src/event_slot.sv
/*
  One pending event slot: remembers that an event fired and the time stamp taken
  at that moment, until the event record is handed out.
  Assumes the owner asserts take only while pending is high.
*/
`timescale 1ns/1ps
module event_slot (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic take,
  input wire logic [common_sig_pkg::STAMP_W-1:0] stamp_in,
  output logic pending,
  output logic [common_sig_pkg::STAMP_W-1:0] stamp
);

  logic pending_reg;
  logic pending_next;
  logic [common_sig_pkg::STAMP_W-1:0] stamp_reg;
  logic [common_sig_pkg::STAMP_W-1:0] stamp_next;

  // A new event wins over the hand-out in the same cycle
  always_comb begin
    pending_next = fire | (pending_reg & ~take);
    stamp_next = fire ? stamp_in : stamp_reg;
  end

  // Slot registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
      stamp_reg <= 32'h0000_0000;
    end else begin
      pending_reg <= pending_next;
      stamp_reg <= stamp_next;
    end
  end

  assign pending = pending_reg;
  assign stamp = stamp_reg;

endmodule : event_slot

//--- src/shared_signal_event_block.sv
/*
  Common start/trip aggregator with APB registers, forcing, condition report,
  time-stamped ON/OFF events, cumulative counters and a level interrupt.
  Assumes stage, extra and time stamp inputs synchronous to pclk; the main event
  buffer accepts one record per cycle.
*/
// Function
// - Shared start/trip high when any active stage starts or trips.
// - Selected extra-start signals also drive the shared start.
// - Selected extra-trip signals also drive the shared trip.
// - Forced selector Normal/Start/Trip, default Normal, usable only with forcing permission.
// - Setting group changes leave forced selector and general settings untouched.
// - No blocking input; suppression happens inside the stages.
// - Readable condition Normal, Start or Trip following the outputs.
// - Four events: start on, start off, trip on, trip off.
// - Events reach the event buffer per masking: ON only, OFF only, both.
// - Start and trip counters count their ON events, clear on request.
// - Every event carries the time stamp of its status change.
// - Shared outputs drive both output contacts and user logic.
`timescale 1ns/1ps
module shared_signal_event_block (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic force_permit,
  input wire logic [2:0] active_group,
  input wire logic [common_sig_pkg::NUM_STAGES-1:0] stage_active,
  input wire logic [common_sig_pkg::NUM_STAGES-1:0] stage_start,
  input wire logic [common_sig_pkg::NUM_STAGES-1:0] stage_trip,
  input wire logic [common_sig_pkg::NUM_EXTRA-1:0] extra_signal,
  input wire logic [common_sig_pkg::STAMP_W-1:0] time_stamp,
  output logic relay_start,
  output logic relay_trip,
  output logic logic_start,
  output logic logic_trip,
  output common_sig_pkg::event_rec_t event_out,
  output logic irq
);

  // Register state
  common_sig_pkg::ctrl_t ctrl_reg;
  common_sig_pkg::ctrl_t ctrl_next;
  logic [common_sig_pkg::NUM_EXTRA-1:0] start_sel_reg;
  logic [common_sig_pkg::NUM_EXTRA-1:0] start_sel_next;
  logic [common_sig_pkg::NUM_EXTRA-1:0] trip_sel_reg;
  logic [common_sig_pkg::NUM_EXTRA-1:0] trip_sel_next;
  logic [common_sig_pkg::NUM_EVENTS-1:0] irq_mask_reg;
  logic [common_sig_pkg::NUM_EVENTS-1:0] irq_mask_next;
  logic [common_sig_pkg::NUM_EVENTS-1:0] irq_stat_reg;
  logic [common_sig_pkg::NUM_EVENTS-1:0] irq_stat_next;
  logic [common_sig_pkg::CNT_W-1:0] start_cnt_reg;
  logic [common_sig_pkg::CNT_W-1:0] start_cnt_next;
  logic [common_sig_pkg::CNT_W-1:0] trip_cnt_reg;
  logic [common_sig_pkg::CNT_W-1:0] trip_cnt_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic irq_reg;
  logic irq_next;

  // Output state
  logic start_reg;
  logic start_next;
  logic trip_reg;
  logic trip_next;
  common_sig_pkg::condition_t cond_reg;
  common_sig_pkg::condition_t cond_next;
  common_sig_pkg::event_rec_t event_reg;
  common_sig_pkg::event_rec_t event_next;
  common_sig_pkg::event_rec_t last_event_reg;
  common_sig_pkg::event_rec_t last_event_next;

  // Combinational helpers
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic cnt_clear;
  logic forcing;
  logic start_calc;
  logic trip_calc;
  logic [common_sig_pkg::NUM_EVENTS-1:0] event_fire;
  logic [common_sig_pkg::NUM_EVENTS-1:0] event_logged;
  logic [common_sig_pkg::NUM_EVENTS-1:0] slot_pending;
  logic [common_sig_pkg::NUM_EVENTS-1:0] slot_take;
  logic [common_sig_pkg::STAMP_W-1:0] slot_stamp [common_sig_pkg::NUM_EVENTS];

  // APB phase decode; writes land and reads clear at the completing edge
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign wr_en = access_done & pwrite & addr_hit;
  assign rd_en = access_done & ~pwrite & addr_hit;
  assign cnt_clear = wr_en & (paddr == common_sig_pkg::ADDR_CTRL) & pwdata[common_sig_pkg::CTRL_CNT_CLR_BIT];

  // Address decode
  always_comb begin
    case (paddr)
      common_sig_pkg::ADDR_CTRL, common_sig_pkg::ADDR_STATUS, common_sig_pkg::ADDR_START_CNT,
      common_sig_pkg::ADDR_TRIP_CNT, common_sig_pkg::ADDR_IRQ_STATUS, common_sig_pkg::ADDR_IRQ_MASK,
      common_sig_pkg::ADDR_EXTRA_START_SEL, common_sig_pkg::ADDR_EXTRA_TRIP_SEL,
      common_sig_pkg::ADDR_LAST_EVENT, common_sig_pkg::ADDR_LAST_STAMP: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Aggregation of stage and extra signals; no blocking term exists here
  always_comb begin
    start_calc = |(stage_active & stage_start) | |(extra_signal & start_sel_reg);
    trip_calc = |(stage_active & stage_trip) | |(extra_signal & trip_sel_reg);
    forcing = force_permit & (ctrl_reg.forced_state_select != common_sig_pkg::FORCE_NORMAL);
    if (forcing) begin
      start_next = 1'b1;
      trip_next = (ctrl_reg.forced_state_select == common_sig_pkg::FORCE_TRIP);
    end else begin
      start_next = start_calc;
      trip_next = trip_calc;
    end
    // Condition follows the outputs being registered now
    if (trip_next) begin
      cond_next = common_sig_pkg::COND_TRIP;
    end else if (start_next) begin
      cond_next = common_sig_pkg::COND_START;
    end else begin
      cond_next = common_sig_pkg::COND_NORMAL;
    end
  end

  // Output edges give exactly one event each
  always_comb begin
    event_fire = '0;
    event_fire[common_sig_pkg::EVT_START_ON] = start_next & ~start_reg;
    event_fire[common_sig_pkg::EVT_START_OFF] = ~start_next & start_reg;
    event_fire[common_sig_pkg::EVT_TRIP_ON] = trip_next & ~trip_reg;
    event_fire[common_sig_pkg::EVT_TRIP_OFF] = ~trip_next & trip_reg;
    case (ctrl_reg.log_mode)
      common_sig_pkg::LOG_ON_ONLY: begin
        event_logged = event_fire & 4'h5;
      end
      common_sig_pkg::LOG_OFF_ONLY: begin
        event_logged = event_fire & 4'hA;
      end
      default: begin
        event_logged = event_fire;
      end
    endcase
  end

  // Pending slots keep each logged event with its own stamp
  genvar gi;
  generate
    for (gi = 0; gi < common_sig_pkg::NUM_EVENTS; gi++) begin : g_slot
      event_slot u_slot (
        .pclk(pclk),
        .presetn(presetn),
        .fire(event_logged[gi]),
        .take(slot_take[gi]),
        .stamp_in(time_stamp),
        .pending(slot_pending[gi]),
        .stamp(slot_stamp[gi])
      );
    end
  endgenerate

  // Hand out the lowest pending event, one per cycle
  always_comb begin
    slot_take = '0;
    event_next = common_sig_pkg::EVENT_REC_RESET;
    for (int i = common_sig_pkg::NUM_EVENTS - 1; i >= 0; i--) begin
      if (slot_pending[i]) begin
        slot_take = '0;
        slot_take[i] = 1'b1;
        event_next.valid = 1'b1;
        event_next.code = i[1:0];
        event_next.stamp = slot_stamp[i];
      end
    end
    last_event_next = event_next.valid ? event_next : last_event_reg;
  end

  // Control settings; no input touches them besides software, so group changes leave them
  always_comb begin
    ctrl_next = ctrl_reg;
    start_sel_next = start_sel_reg;
    trip_sel_next = trip_sel_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_en) begin
      case (paddr)
        common_sig_pkg::ADDR_CTRL: begin
          if (force_permit) begin
            ctrl_next.forced_state_select =
              common_sig_pkg::forced_state_t'(pwdata[common_sig_pkg::CTRL_FORCE_LSB +: 2]);
          end
          ctrl_next.log_mode = common_sig_pkg::log_mode_t'(pwdata[common_sig_pkg::CTRL_LOG_LSB +: 2]);
        end
        common_sig_pkg::ADDR_EXTRA_START_SEL: begin
          start_sel_next = pwdata[common_sig_pkg::NUM_EXTRA-1:0];
        end
        common_sig_pkg::ADDR_EXTRA_TRIP_SEL: begin
          trip_sel_next = pwdata[common_sig_pkg::NUM_EXTRA-1:0];
        end
        common_sig_pkg::ADDR_IRQ_MASK: begin
          irq_mask_next = pwdata[common_sig_pkg::NUM_EVENTS-1:0];
        end
        default: begin
          ctrl_next = ctrl_reg;
        end
      endcase
    end
  end

  // Counters and sticky status; an event in the clearing cycle wins
  always_comb begin
    start_cnt_next = cnt_clear ? '0 : start_cnt_reg;
    trip_cnt_next = cnt_clear ? '0 : trip_cnt_reg;
    if (event_fire[common_sig_pkg::EVT_START_ON]) begin
      start_cnt_next = start_cnt_next + 32'h0000_0001;
    end
    if (event_fire[common_sig_pkg::EVT_TRIP_ON]) begin
      trip_cnt_next = trip_cnt_next + 32'h0000_0001;
    end
    irq_stat_next = irq_stat_reg;
    if (rd_en && (paddr == common_sig_pkg::ADDR_IRQ_STATUS)) begin
      irq_stat_next = '0;
    end
    irq_stat_next = irq_stat_next | event_fire;
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  // APB answer: pready one cycle after setup, read data captured in setup
  always_comb begin
    pready_next = setup_phase;
    pslverr_next = setup_phase & ~addr_hit;
    prdata_next = access_done ? 32'h0000_0000 : prdata_reg;
    if (setup_phase && !pwrite) begin
      case (paddr)
        common_sig_pkg::ADDR_CTRL: begin
          prdata_next = {26'h0000000, ctrl_reg.log_mode, 2'b00, ctrl_reg.forced_state_select};
        end
        common_sig_pkg::ADDR_STATUS: begin
          prdata_next = {27'h0000000, force_permit, trip_reg, start_reg, cond_reg};
        end
        common_sig_pkg::ADDR_START_CNT: prdata_next = start_cnt_reg;
        common_sig_pkg::ADDR_TRIP_CNT: prdata_next = trip_cnt_reg;
        common_sig_pkg::ADDR_IRQ_STATUS: prdata_next = {28'h0000000, irq_stat_reg};
        common_sig_pkg::ADDR_IRQ_MASK: prdata_next = {28'h0000000, irq_mask_reg};
        common_sig_pkg::ADDR_EXTRA_START_SEL: prdata_next = {16'h0000, start_sel_reg};
        common_sig_pkg::ADDR_EXTRA_TRIP_SEL: prdata_next = {16'h0000, trip_sel_reg};
        common_sig_pkg::ADDR_LAST_EVENT: prdata_next = {29'h00000000, last_event_reg.valid, last_event_reg.code};
        common_sig_pkg::ADDR_LAST_STAMP: prdata_next = last_event_reg.stamp;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // All registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= common_sig_pkg::CTRL_RESET;
      start_sel_reg <= common_sig_pkg::EXTRA_SEL_RESET;
      trip_sel_reg <= common_sig_pkg::EXTRA_SEL_RESET;
      irq_mask_reg <= common_sig_pkg::IRQ_MASK_RESET;
      irq_stat_reg <= 4'h0;
      start_cnt_reg <= 32'h0000_0000;
      trip_cnt_reg <= 32'h0000_0000;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
      start_reg <= 1'b0;
      trip_reg <= 1'b0;
      cond_reg <= common_sig_pkg::COND_NORMAL;
      event_reg <= common_sig_pkg::EVENT_REC_RESET;
      last_event_reg <= common_sig_pkg::EVENT_REC_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      start_sel_reg <= start_sel_next;
      trip_sel_reg <= trip_sel_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      start_cnt_reg <= start_cnt_next;
      trip_cnt_reg <= trip_cnt_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
      start_reg <= start_next;
      trip_reg <= trip_next;
      cond_reg <= cond_next;
      event_reg <= event_next;
      last_event_reg <= last_event_next;
    end
  end

  // Shared signals fan out to contacts and user logic from the same flops
  assign relay_start = start_reg;
  assign relay_trip = trip_reg;
  assign logic_start = start_reg;
  assign logic_trip = trip_reg;
  assign event_out = event_reg;
  assign irq = irq_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule : shared_signal_event_block

//--- verification/shared_signal_asserts.sv
/*
  Checker for the shared start/trip block: output causes, event stamps and APB answers.
  Assumes it is bound to shared_signal_event_block and sees only its ports.
*/
`timescale 1ns/1ps
module shared_signal_asserts (
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr, force_permit,
  input wire logic [2:0] active_group,
  input wire logic [31:0] stage_active, stage_start, stage_trip, time_stamp,
  input wire logic [15:0] extra_signal,
  input wire logic relay_start, relay_trip, logic_start, logic_trip, irq,
  input wire common_sig_pkg::event_rec_t event_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Stage causes and their absence
  property p_start_any; |(stage_active & stage_start) |=> relay_start; endproperty
  a_start_any: assert property (p_start_any) else $error("shared start missing");
  property p_trip_any; !force_permit && |(stage_active & stage_trip) |=> relay_trip; endproperty
  a_trip_any: assert property (p_trip_any) else $error("shared trip missing");
  property p_start_idle;
    !force_permit && !(|(stage_active & stage_start)) && extra_signal == 16'h0000 |=> !relay_start;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("shared start without cause");
  property p_trip_idle;
    !force_permit && !(|(stage_active & stage_trip)) && extra_signal == 16'h0000 |=> !relay_trip;
  endproperty
  a_trip_idle: assert property (p_trip_idle) else $error("shared trip without cause");
  property p_outputs_same; relay_start == logic_start && relay_trip == logic_trip; endproperty
  a_outputs_same: assert property (p_outputs_same) else $error("contact and logic outputs differ");
  // Event records carry the stamp of the input change
  property p_start_event;
    $rose(relay_start) ##1 event_out.valid |-> event_out.code == 2'h0 && event_out.stamp == $past(time_stamp, 2);
  endproperty
  a_start_event: assert property (p_start_event) else $error("start event record wrong");
  property p_trip_event;
    $rose(relay_trip) && $stable(relay_start) ##1 event_out.valid
      |-> event_out.code == 2'h2 && event_out.stamp == $past(time_stamp, 2);
  endproperty
  a_trip_event: assert property (p_trip_event) else $error("trip event record wrong");
  // Register access answers
  property p_apb_answer; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("access answer timing wrong");
  property p_apb_err; pslverr |-> pready; endproperty
  a_apb_err: assert property (p_apb_err) else $error("error without ready");
endmodule : shared_signal_asserts

//--- verification/stage_model.sv
/*
  Model of the protection stages: registers the stage levels the bench asks for
  and runs a free time counter. Assumes the block's clock and reset.
*/
`timescale 1ns/1ps
module stage_model (
  input wire logic pclk, presetn,
  input wire logic [31:0] want_active, want_start, want_trip,
  output logic [31:0] stage_active, stage_start, stage_trip, time_stamp
);
  // Stages change only on the program cycle edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_active <= 32'h0;
      stage_start <= 32'h0;
      stage_trip <= 32'h0;
      time_stamp <= 32'h0;
    end else begin
      stage_active <= want_active;
      stage_start <= want_start;
      stage_trip <= want_trip;
      time_stamp <= time_stamp + 32'h1;
    end
  end
endmodule : stage_model

//--- verification/testbench.sv
/*
  Testbench for the shared start/trip block: APB tasks, stage model, event monitor.
  Assumes the checker is bound below and the stage model feeds the stage inputs.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, force_permit = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, want_a = 32'h0, want_s = 32'h0, want_t = 32'h0;
  logic [31:0] prdata, st_a, st_s, st_t, tstamp, rd;
  logic pready, pslverr, relay_start, relay_trip, logic_start, logic_trip, irq, err;
  logic [2:0] active_group = 3'h0;
  logic [15:0] extra_signal = 16'h0;
  common_sig_pkg::event_rec_t event_out;
  common_sig_pkg::event_rec_t evq[$];
  int fails = 0, compares = 0, cycles = 0;
  always #2.5 pclk = ~pclk;
  shared_signal_event_block dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .force_permit(force_permit), .active_group(active_group), .stage_active(st_a), .stage_start(st_s),
    .stage_trip(st_t), .extra_signal(extra_signal), .time_stamp(tstamp), .relay_start(relay_start),
    .relay_trip(relay_trip), .logic_start(logic_start), .logic_trip(logic_trip), .event_out(event_out),
    .irq(irq));
  stage_model model_u (.pclk(pclk), .presetn(presetn), .want_active(want_a), .want_start(want_s),
    .want_trip(want_t), .stage_active(st_a), .stage_start(st_s), .stage_trip(st_t), .time_stamp(tstamp));
  task final_report;
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Gather event records and cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (event_out.valid === 1'b1) evq.push_back(event_out);
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  task stage(input logic [31:0] a, input logic [31:0] s, input logic [31:0] t);
    @(posedge pclk);
    want_a <= a; want_s <= s; want_t <= t;
    repeat (4) @(posedge pclk);
  endtask : stage
  task ext(input logic [15:0] x);
    @(posedge pclk);
    extra_signal <= x;
    repeat (3) @(posedge pclk);
  endtask : ext
  // Main sequence of register and stage scenarios
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) rdchk(8'(i * 4), 32'h0);
    rdchk(8'h40, 32'h0);
    `CHK(err, 1'b1)
    stage(32'h8, 32'h28, 32'h0);
    `CHK({relay_start, logic_start, relay_trip, logic_trip}, 4'hC)
    rdchk(common_sig_pkg::ADDR_STATUS, 32'h5);
    stage(32'h8, 32'h8, 32'h8);
    rdchk(common_sig_pkg::ADDR_STATUS, 32'hE);
    stage(32'h0, 32'h0, 32'h0);
    rdchk(common_sig_pkg::ADDR_TRIP_CNT, 32'h1);
    xfer(1'b1, common_sig_pkg::ADDR_CTRL, 32'h100);
    rdchk(common_sig_pkg::ADDR_START_CNT, 32'h0);
    xfer(1'b1, common_sig_pkg::ADDR_EXTRA_START_SEL, 32'h10);
    xfer(1'b1, common_sig_pkg::ADDR_EXTRA_TRIP_SEL, 32'h8000);
    ext(16'h0020);
    `CHK({relay_start, relay_trip}, 2'b00)
    ext(16'h0010);
    `CHK({relay_start, relay_trip}, 2'b10)
    ext(16'h8000);
    `CHK({relay_start, relay_trip}, 2'b01)
    ext(16'h0000);
    xfer(1'b1, common_sig_pkg::ADDR_CTRL, 32'h2);
    rdchk(common_sig_pkg::ADDR_CTRL, 32'h0);
    force_permit <= 1'b1;
    xfer(1'b1, common_sig_pkg::ADDR_CTRL, 32'h2);
    rdchk(common_sig_pkg::ADDR_STATUS, 32'h1E);
    active_group <= 3'h5;
    rdchk(common_sig_pkg::ADDR_CTRL, 32'h2);
    xfer(1'b1, common_sig_pkg::ADDR_CTRL, 32'h1);
    rdchk(common_sig_pkg::ADDR_STATUS, 32'h15);
    force_permit <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK({relay_start, relay_trip}, 2'b00)
    for (int m = 0; m < 3; m++) begin
      xfer(1'b1, common_sig_pkg::ADDR_CTRL, 32'(m) << 4);
      evq.delete();
      stage(32'h1, 32'h1, 32'h0);
      stage(32'h0, 32'h0, 32'h0);
      // Let the last record reach the monitor before looking at the queue
      repeat (2) @(posedge pclk);
      `CHK(evq.size(), (m == 0) ? 2 : 1)
      `CHK(evq[0].code, (m == 2) ? 2'h1 : 2'h0)
      if (m == 0) `CHK(evq[1].stamp - evq[0].stamp, 32'h5)
    end
    xfer(1'b1, common_sig_pkg::ADDR_CTRL, 32'h0);
    evq.delete();
    stage(32'h1, 32'h1, 32'h1);
    stage(32'h0, 32'h0, 32'h0);
    // Two OFF records leave one per cycle; wait for both to be gathered
    repeat (2) @(posedge pclk);
    `CHK({evq[0].code, evq[1].code, evq[2].code, evq[3].code}, 8'h27)
    rdchk(common_sig_pkg::ADDR_START_CNT, 32'h6);
    rdchk(common_sig_pkg::ADDR_TRIP_CNT, 32'h3);
    stage(32'h1, 32'h0, 32'h1);
    stage(32'h0, 32'h0, 32'h0);
    xfer(1'b0, common_sig_pkg::ADDR_IRQ_STATUS, 32'h0);
    xfer(1'b1, common_sig_pkg::ADDR_IRQ_MASK, 32'h1);
    stage(32'h1, 32'h1, 32'h0);
    `CHK(irq, 1'b1)
    rdchk(common_sig_pkg::ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    stage(32'h0, 32'h0, 32'h0);
    `CHK(irq, 1'b0)
    rdchk(common_sig_pkg::ADDR_IRQ_STATUS, 32'h2);
    rdchk(common_sig_pkg::ADDR_LAST_EVENT, 32'h5);
    final_report();
  end
endmodule : testbench
bind shared_signal_event_block shared_signal_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .force_permit(force_permit), .active_group(active_group), .stage_active(stage_active),
  .stage_start(stage_start), .stage_trip(stage_trip), .time_stamp(time_stamp), .extra_signal(extra_signal),
  .relay_start(relay_start), .relay_trip(relay_trip), .logic_start(logic_start), .logic_trip(logic_trip),
  .irq(irq), .event_out(event_out));
